// >>> design/lsic_indicator.sv
// indicator configuration register and three indicator drivers for one port
`timescale 1ns/100ps
`include "lsic_params.svh"

module lsic_indicator #(
	parameter int unsigned FAST_HALF = `LSIC_MS_CYCLES(`LSIC_FAST_MS) / 2,
	parameter int unsigned SLOW_HALF = `LSIC_MS_CYCLES(`LSIC_SLOW_MS) / 2,
	parameter int unsigned STR0      = `LSIC_MS_CYCLES(`LSIC_STRETCH0_MS),
	parameter int unsigned STR1      = `LSIC_MS_CYCLES(`LSIC_STRETCH1_MS),
	parameter int unsigned STR2      = `LSIC_MS_CYCLES(`LSIC_STRETCH2_MS)
) (
	// clock and reset
	input  wire logic                    clk_sys,
	input  wire logic                    reset_n,
	// management register access
	input  wire lsic_pkg::lsic_reg_req_t reg_req,
	output logic [15:0]                  reg_rdata,
	// port status, same clock
	input  wire lsic_pkg::lsic_status_t  status,
	// indicator lamps, high means lit
	output logic [2:0]                   indicator
);
	import lsic_pkg::*;

	localparam int unsigned CW = 24;

	logic [15:0]   cfg_ff, nxt_cfg;
	logic [15:0]   rdata_ff, nxt_rdata;
	logic [CW-1:0] fast_cnt_ff, nxt_fast_cnt;
	logic [CW-1:0] slow_cnt_ff, nxt_slow_cnt;
	logic          fast_ff, nxt_fast;
	logic          slow_ff, nxt_slow;
	logic [CW-1:0] str_len;
	logic [3:0]    sel [3];
	logic [2:0]    ind_ff, nxt_ind;

	// ----------------------------------------
	// configuration register
	// ----------------------------------------
	always_comb begin
		nxt_cfg   = cfg_ff;
		nxt_rdata = cfg_ff;
		if (reg_req.wr && reg_req.addr == `LSIC_CFG_ADDR) begin
			nxt_cfg = reg_req.wdata;
		end
		if (reg_req.addr != `LSIC_CFG_ADDR) begin
			nxt_rdata = 16'h0000;
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			cfg_ff   <= `LSIC_CFG_RESET;
			rdata_ff <= 16'h0000;
		end else begin
			cfg_ff   <= nxt_cfg;
			rdata_ff <= nxt_rdata;
		end
	end

	assign reg_rdata = rdata_ff;
	assign sel[0] = cfg_ff[`LSIC_SEL1_HI:`LSIC_SEL1_LO];
	assign sel[1] = cfg_ff[`LSIC_SEL2_HI:`LSIC_SEL2_LO];
	assign sel[2] = cfg_ff[`LSIC_SEL3_HI:`LSIC_SEL3_LO];

	// ----------------------------------------
	// blink timebase
	// ----------------------------------------
	always_comb begin
		nxt_fast_cnt = fast_cnt_ff + 1'b1;
		nxt_slow_cnt = slow_cnt_ff + 1'b1;
		nxt_fast     = fast_ff;
		nxt_slow     = slow_ff;
		if (fast_cnt_ff >= CW'(FAST_HALF - 1)) begin
			nxt_fast_cnt = '0;
			nxt_fast     = ~fast_ff;
		end
		if (slow_cnt_ff >= CW'(SLOW_HALF - 1)) begin
			nxt_slow_cnt = '0;
			nxt_slow     = ~slow_ff;
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			fast_cnt_ff <= '0;
			slow_cnt_ff <= '0;
			fast_ff     <= 1'b0;
			slow_ff     <= 1'b0;
		end else begin
			fast_cnt_ff <= nxt_fast_cnt;
			slow_cnt_ff <= nxt_slow_cnt;
			fast_ff     <= nxt_fast;
			slow_ff     <= nxt_slow;
		end
	end

	// reserved duration code falls back to the longest figure
	always_comb begin
		case (cfg_ff[`LSIC_DUR_HI:`LSIC_DUR_LO])
			2'b00:   str_len = CW'(STR0);
			2'b01:   str_len = CW'(STR1);
			default: str_len = CW'(STR2);
		endcase
	end

	// ----------------------------------------
	// per-indicator display
	// ----------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_ind
			logic [CW-1:0] hold_ff, nxt_hold;
			logic          tgl_ff, nxt_tgl;
			logic          ev;
			logic          base;
			logic          comb;
			logic          valid;
			logic          level;
			logic          evm;
			logic          nxt_bit;

			always_comb begin
				ev    = 1'b0;
				base  = 1'b0;
				comb  = 1'b0;
				valid = 1'b1;
				level = 1'b0;
				case (sel[gi])
					LSIC_SEL_SPEED:  level = status.speed;
					LSIC_SEL_TX:     ev    = status.tx;
					LSIC_SEL_RX:     ev    = status.rx;
					LSIC_SEL_COL:    ev    = status.col;
					LSIC_SEL_LINK:   level = status.link;
					// duplex follows its flag, which may lag link loss
					LSIC_SEL_DUPLEX: level = status.duplex;
					LSIC_SEL_ACT:    ev    = status.rx | status.tx;
					LSIC_SEL_ON:     level = 1'b1;
					LSIC_SEL_OFF:    level = 1'b0;
					LSIC_SEL_FAST:   level = fast_ff;
					LSIC_SEL_SLOW:   level = slow_ff;
					LSIC_SEL_LINK_RX: begin
						comb = 1'b1;
						base = status.link;
						ev   = status.rx | status.tx | status.isolate;
					end
					LSIC_SEL_LINK_ACT: begin
						comb  = 1'b1;
						valid = (gi == 2);
						base  = status.link;
						ev    = status.rx | status.tx;
					end
					LSIC_SEL_DUP_COL: begin
						comb = 1'b1;
						base = status.duplex;
						ev   = status.col;
					end
					default: valid = 1'b0;
				endcase

				// of the plain codes only event codes show the stretch; a leftover count must not light others
				evm = sel[gi] inside {LSIC_SEL_TX, LSIC_SEL_RX, LSIC_SEL_COL, LSIC_SEL_ACT};
				nxt_hold = (hold_ff != '0) ? hold_ff - 1'b1 : '0;
				nxt_tgl  = tgl_ff;
				if (ev && (comb || cfg_ff[`LSIC_STRETCH_BIT])) begin
					nxt_hold = str_len;
				end
				if (comb && hold_ff != '0) begin
					// toggling at blink rate while events keep the stretch alive
					nxt_tgl = fast_ff;
				end else begin
					nxt_tgl = 1'b0;
				end

				if (!valid) begin
					nxt_bit = 1'b0;
				end else if (comb) begin
					nxt_bit = base ^ tgl_ff;
				end else begin
					nxt_bit = level | ev | (evm && hold_ff != '0);
				end
			end

			always_ff @(posedge clk_sys or negedge reset_n) begin
				if (!reset_n) begin
					hold_ff <= '0;
					tgl_ff  <= 1'b0;
				end else begin
					hold_ff <= nxt_hold;
					tgl_ff  <= nxt_tgl;
				end
			end
		end
	endgenerate

	always_comb begin
		nxt_ind = {g_ind[2].nxt_bit, g_ind[1].nxt_bit, g_ind[0].nxt_bit};
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			ind_ff <= 3'b000;
		end else begin
			ind_ff <= nxt_ind;
		end
	end

	assign indicator = ind_ff;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	a_cfg_write: assert property (@(posedge clk_sys) disable iff (!reset_n)
		reg_req.wr && reg_req.addr == `LSIC_CFG_ADDR |=> cfg_ff == $past(reg_req.wdata))
		else $error("config write not stored");
	a_force_on: assert property (@(posedge clk_sys) disable iff (!reset_n)
		sel[0] == 4'h8 |=> indicator[0]) else $error("forced on not lit");
	a_force_off: assert property (@(posedge clk_sys) disable iff (!reset_n)
		sel[1] == 4'h9 |=> !indicator[1]) else $error("forced off lit");
	a_reserved_off: assert property (@(posedge clk_sys) disable iff (!reset_n)
		sel[2] == 4'h6 || sel[2] == 4'hF |=> !indicator[2]) else $error("reserved lit");
	a_code_d_only3: assert property (@(posedge clk_sys) disable iff (!reset_n)
		sel[0] == 4'hD |=> !indicator[0]) else $error("code 1101 on first");
	a_link_follow: assert property (@(posedge clk_sys) disable iff (!reset_n)
		sel[1] == 4'h4 |=> indicator[1] == $past(status.link)) else $error("link mismatch");
	a_act_or: assert property (@(posedge clk_sys) disable iff (!reset_n)
		sel[2] == 4'h7 && (status.rx || status.tx) |=> indicator[2])
		else $error("activity not lit");
	a_no_stretch: assert property (@(posedge clk_sys) disable iff (!reset_n)
		!cfg_ff[1] && sel[0] == 4'h1 && !status.tx && g_ind[0].hold_ff == '0
		|=> !indicator[0]) else $error("stretched while disabled");
	a_comb_stretch: assert property (@(posedge clk_sys) disable iff (!reset_n)
		sel[0] == 4'hE && status.col |=> g_ind[0].hold_ff == $past(str_len))
		else $error("combined not stretched");
endmodule // lsic_indicator

// >>> shared/lsic_params.svh
// offsets, field positions, reset values and timing figures for the indicator control block
`ifndef LSIC_PARAMS_SVH
`define LSIC_PARAMS_SVH

`define LSIC_CFG_ADDR      5'h14
`define LSIC_SEL1_HI       15
`define LSIC_SEL1_LO       12
`define LSIC_SEL2_HI       11
`define LSIC_SEL2_LO       8
`define LSIC_SEL3_HI       7
`define LSIC_SEL3_LO       4
`define LSIC_DUR_HI        3
`define LSIC_DUR_LO        2
`define LSIC_STRETCH_BIT   1
`define LSIC_CFG_RESET     16'h0422
`define LSIC_CLK_HZ        20000000
`define LSIC_STRETCH0_MS   30
`define LSIC_STRETCH1_MS   60
`define LSIC_STRETCH2_MS   100
`define LSIC_FAST_MS       100
`define LSIC_SLOW_MS       500
`define LSIC_MS_CYCLES(ms) ((ms) * (`LSIC_CLK_HZ / 1000))

`endif

// >>> shared/lsic_pkg.sv
// types shared by the indicator control block
package lsic_pkg;
	typedef enum logic [3:0] {
		LSIC_SEL_SPEED    = 4'h0,
		LSIC_SEL_TX       = 4'h1,
		LSIC_SEL_RX       = 4'h2,
		LSIC_SEL_COL      = 4'h3,
		LSIC_SEL_LINK     = 4'h4,
		LSIC_SEL_DUPLEX   = 4'h5,
		LSIC_SEL_ACT      = 4'h7,
		LSIC_SEL_ON       = 4'h8,
		LSIC_SEL_OFF      = 4'h9,
		LSIC_SEL_FAST     = 4'hA,
		LSIC_SEL_SLOW     = 4'hB,
		LSIC_SEL_LINK_RX  = 4'hC,
		LSIC_SEL_LINK_ACT = 4'hD,
		LSIC_SEL_DUP_COL  = 4'hE
	} lsic_sel_t;

	// port status from the transceiver core
	typedef struct packed {
		logic speed;
		logic tx;
		logic rx;
		logic col;
		logic link;
		logic duplex;
		logic isolate;
	} lsic_status_t;

	// management register access
	typedef struct packed {
		logic        wr;
		logic [4:0]  addr;
		logic [15:0] wdata;
	} lsic_reg_req_t;
endpackage

// >>> testbench/lsic_lamp_model.sv
// lamp model: follows the drive lines and counts lamp changes
`timescale 1ns/100ps
module lsic_lamp_model (
	// clock and control
	input  wire logic       clk_sys,
	input  wire logic       clear,
	// lamp drives and observation
	input  wire logic [2:0] indicator,
	output logic [7:0]      flips
);
	logic [2:0] last_ff;
	logic [7:0] flips_ff;
	logic [7:0] nxt_flips;
	always_comb begin
		nxt_flips = flips_ff;
		if (clear)
			nxt_flips = 8'h00;
		else if (indicator != last_ff)
			nxt_flips = flips_ff + 8'h01;
	end
	always_ff @(posedge clk_sys) begin
		last_ff  <= indicator;
		flips_ff <= nxt_flips;
	end
	assign flips = flips_ff;
endmodule // lsic_lamp_model

// >>> testbench/test_led_status_indicator_control.sv
// self-checking bench for the indicator control block
`timescale 1ns/100ps
module test_led_status_indicator_control;
	import lsic_pkg::*;
	logic          clk_sys;
	logic          reset_n;
	logic          clear;
	lsic_reg_req_t reg_req;
	lsic_status_t  status;
	logic [15:0]   reg_rdata;
	logic [2:0]    indicator;
	logic [7:0]    flips;
	int            n_mismatch;
	int            checks;
	int            cyc;
	logic [15:0]   tv [8] = '{16'h7101, 16'h7201, 16'h7000, 16'h87F1,
		16'h97F0, 16'h67F0, 16'hF7F0, 16'hD7F0};
	logic [31:0]   cv [4] = '{32'hC904_1401, 32'hC904_0501, 32'hE902_0A01, 32'h9D04_2404};

	lsic_indicator #(.FAST_HALF(4), .SLOW_HALF(8), .STR0(5), .STR1(6), .STR2(7)) uut (
		.clk_sys(clk_sys), .reset_n(reset_n), .reg_req(reg_req),
		.reg_rdata(reg_rdata), .status(status), .indicator(indicator));
	lsic_lamp_model lamps (.clk_sys(clk_sys), .clear(clear), .indicator(indicator),
		.flips(flips));

	// ----------------------------
	// tasks
	// ----------------------------
	task automatic tick(input int n);
		repeat (n) @(negedge clk_sys);
	endtask
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		reg_req = '{1'b1, a, d};
		tick(1);
		reg_req.wr = 1'b0;
	endtask
	task automatic rd(input logic [4:0] a, input logic [15:0] exp);
		reg_req.addr = a;
		tick(1);
		chk("reg_rdata", exp, reg_rdata);
	endtask
	task automatic lamp(input logic [2:0] exp, input int n);
		tick(n);
		chk("indicator", {13'h0000, exp}, {13'h0000, indicator});
	endtask
	task automatic clr();
		clear = 1'b1;
		tick(1);
		clear = 1'b0;
	endtask
	// first and third selectors, second held off, stretch fields
	function automatic logic [15:0] cf(logic [3:0] s1, logic [3:0] s3, logic [1:0] d,
		logic st);
		return {s1, 4'h9, s3, d, st, 1'b0};
	endfunction
	task automatic finish_test();
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// ----------------------------
	// clock, timeout, sequence
	// ----------------------------
	initial begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 3000) begin
			n_mismatch++;
			finish_test();
		end
	end
	initial begin
		reset_n = 1'b0;
		reg_req = '{1'b0, 5'h14, 16'h0000};
		status = '0;
		clear = 1'b0;
		tick(10);
		reset_n = 1'b1;
		rd(5'h14, 16'h0422);
		rd(5'h13, 16'h0000);
		wr(5'h13, 16'hFFFF);
		rd(5'h14, 16'h0422);
		wr(5'h14, 16'hFFFF);
		rd(5'h14, 16'hFFFF);
		$display("test registers done");
		for (int c = 0; c < 6; c++) begin
			wr(5'h14, cf(c[3:0], 4'h9, 2'b00, 1'b0));
			status = 7'h40 >> c;
			lamp(3'h1, 3);
			status = ~(7'h40 >> c);
			lamp(3'h0, 3);
		end
		foreach (tv[i]) begin
			wr(5'h14, cf(tv[i][15:12], 4'h9, 2'b00, 1'b0));
			status = tv[i][10:4];
			lamp({2'b00, tv[i][0]}, 3);
		end
		$display("test selectors done");
		for (int h = 4; h <= 8; h += 4) begin
			wr(5'h14, cf((h == 4) ? 4'hA : 4'hB, 4'h9, 2'b00, 1'b0));
			clr();
			tick(40);
			chk("blink flips", 16'h0001, {15'h0000, flips >= 40 / h - 1 && flips <= 40 / h + 1});
		end
		for (int d = 0; d < 4; d++) begin
			// no stretch at d == 3, to see the enable bit at work
			wr(5'h14, cf(4'h1, 4'h9, d[1:0], d != 3));
			status = 7'h20;
			tick(1);
			status = '0;
			if (d == 3)
				lamp(3'h0, 3);
			else begin
				lamp(3'h1, 5 + d);
				lamp(3'h0, 1);
			end
		end
		$display("test stretch done");
		foreach (cv[i]) begin
			wr(5'h14, cf(cv[i][31:28], cv[i][27:24], 2'b00, 1'b0));
			status = cv[i][22:16];
			lamp(cv[i][2:0], 4);
			clr();
			lamp(cv[i][2:0], 6);
			chk("steady flips", 16'h0000, {8'h00, flips});
			status = cv[i][14:8];
			tick(1);
			status = cv[i][22:16];
			tick(8);
			chk("combined blink", 16'h0001, {15'h0000, flips != 8'h00});
		end
		$display("test combined done");
		finish_test();
	end
endmodule // test_led_status_indicator_control
